// *** logic/csp_pkg.sv ***
// constants for the code segment protection block: register map,
// field layout, reset values and decoded segment limits.
// assumes a 32-bit classic wishbone register port and byte addresses.
package csp_pkg;

  localparam int CSP_FA_W = 24;
  localparam int CSP_RA_W = 16;
  localparam int CSP_CNT_W = 16;

  // register byte offsets
  localparam logic [7:0] CSP_OFS_BOOT_CFG = 8'h00;
  localparam logic [7:0] CSP_OFS_SECURE_CFG = 8'h04;
  localparam logic [7:0] CSP_OFS_BOOT_END = 8'h08;
  localparam logic [7:0] CSP_OFS_SECURE_END = 8'h0c;
  localparam logic [7:0] CSP_OFS_RAM_LIMIT = 8'h10;
  localparam logic [7:0] CSP_OFS_STATUS = 8'h14;
  localparam logic [7:0] CSP_OFS_DENY_CNT = 8'h18;

  // field positions in both config words
  localparam int CSP_WP_BIT = 0;
  localparam int CSP_SIZE_LSB = 1;
  localparam int CSP_RAM_LSB = 4;
  localparam int CSP_CFG_W = 6;

  // erased config storage reads all ones: writable, no segments
  localparam logic [5:0] CSP_CFG_RST = 6'h3f;

  // status register bits
  localparam int CSP_ST_BOOT_ON = 0;
  localparam int CSP_ST_SEC_ON = 1;
  localparam int CSP_ST_BOOT_HI = 2;
  localparam int CSP_ST_SEC_HI = 3;
  localparam int CSP_ST_BRAM_ON = 4;
  localparam int CSP_ST_SRAM_ON = 5;
  localparam int CSP_ST_SMALL = 6;

  // flash segment size codes, low two bits (top bit is security level)
  localparam logic [1:0] CSP_SZ_NONE = 2'h3;
  localparam logic [1:0] CSP_SZ_SMALL = 2'h2;
  localparam logic [1:0] CSP_SZ_MID = 2'h1;
  localparam logic [1:0] CSP_SZ_LARGE = 2'h0;

  localparam logic [23:0] CSP_FLASH_BASE = 24'h000000;
  localparam logic [23:0] CSP_ADDR_STEP = 24'h000002;
  localparam logic [23:0] CSP_END_1K = 24'h0007fe;
  localparam logic [23:0] CSP_END_4K = 24'h001ffe;
  localparam logic [23:0] CSP_END_8K = 24'h003ffe;
  localparam logic [23:0] CSP_END_16K = 24'h007ffe;

  // ram protection codes and sizes in bytes
  localparam logic [1:0] CSP_RAM_NONE = 2'h3;
  localparam logic [1:0] CSP_RAM_S = 2'h2;
  localparam logic [1:0] CSP_RAM_M = 2'h1;
  localparam logic [1:0] CSP_RAM_L = 2'h0;
  localparam logic [15:0] CSP_BRAM_S = 16'h0080;
  localparam logic [15:0] CSP_BRAM_M = 16'h0100;
  localparam logic [15:0] CSP_BRAM_L = 16'h0400;
  localparam logic [15:0] CSP_SRAM_S = 16'h0100;
  localparam logic [15:0] CSP_SRAM_M = 16'h0800;
  localparam logic [15:0] CSP_SRAM_L = 16'h1000;
  localparam logic [15:0] CSP_RAM_BASE = 16'h0800;

endpackage

// *** logic/csp_range_chk.sv ***
// inclusive address window compare, used for each protected segment.
// assumes lo and hi are stable decoded limits; hit is combinational.
`timescale 1ns/1ps

module csp_range_chk #(
  parameter int W = 24
) (
  input wire logic [W-1:0] addr,
  input wire logic [W-1:0] lo,
  input wire logic [W-1:0] hi,
  input wire logic valid,
  output logic hit
);

  assign hit = valid && (addr >= lo) && (addr <= hi);

endmodule

// *** logic/csp_top.sv ***
// code segment protection: decodes boot and secure segment settings
// into flash and ram windows and gates write requests against them.
// assumes config storage is written over classic wishbone, and that
// requests are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps

module csp_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic small_variant,
  input wire logic flash_wr_req,
  input wire logic [csp_pkg::CSP_FA_W-1:0] flash_wr_addr,
  output logic flash_wr_go,
  output logic flash_wr_deny,
  input wire logic ram_wr_req,
  input wire logic [csp_pkg::CSP_RA_W-1:0] ram_wr_addr,
  output logic ram_wr_go,
  output logic ram_wr_deny
);
  import csp_pkg::*;

  logic [CSP_CFG_W-1:0] boot_config_word_r;
  logic [CSP_CFG_W-1:0] secure_config_word_r;
  logic small_r;
  logic [CSP_CNT_W-1:0] deny_cnt_r;
  logic [CSP_CNT_W-1:0] deny_cnt_nxt;

  logic boot_write_protect;
  logic [2:0] boot_segment_size_code;
  logic [1:0] boot_ram_size_code;
  logic secure_write_protect;
  logic [2:0] secure_segment_size_code;
  logic [1:0] secure_ram_size_code;

  // decoded limits
  logic boot_on_r;
  logic [CSP_FA_W-1:0] boot_end_r;
  logic sec_on_r;
  logic [CSP_FA_W-1:0] sec_lo_r;
  logic [CSP_FA_W-1:0] sec_end_r;
  logic bram_on_r;
  logic [CSP_RA_W-1:0] bram_size_r;
  logic sram_on_r;
  logic [CSP_RA_W-1:0] sram_size_r;
  logic [CSP_FA_W-1:0] boot_end_nxt;
  logic [CSP_FA_W-1:0] sec_end_nxt;
  logic [CSP_RA_W-1:0] bram_size_nxt;
  logic [CSP_RA_W-1:0] sram_total;

  logic [CSP_RA_W-1:0] bram_hi;
  logic [CSP_RA_W-1:0] sram_lo;
  logic [CSP_RA_W-1:0] sram_hi;
  logic hit_boot_f;
  logic hit_sec_f;
  logic hit_boot_r;
  logic hit_sec_r;

  logic wb_req;
  logic wb_wr_lane0;
  logic [31:0] rd_data;

  assign boot_write_protect = boot_config_word_r[CSP_WP_BIT];
  assign boot_segment_size_code =
    boot_config_word_r[CSP_SIZE_LSB +: 3];
  assign boot_ram_size_code = boot_config_word_r[CSP_RAM_LSB +: 2];
  assign secure_write_protect = secure_config_word_r[CSP_WP_BIT];
  assign secure_segment_size_code =
    secure_config_word_r[CSP_SIZE_LSB +: 3];
  assign secure_ram_size_code = secure_config_word_r[CSP_RAM_LSB +: 2];

  ////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle per request

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr_lane0 = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // config words change at once; the decode below follows one edge later
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_config_word_r <= CSP_CFG_RST;
      secure_config_word_r <= CSP_CFG_RST;
    end else if (wb_wr_lane0) begin
      if (wb_adr_i == CSP_OFS_BOOT_CFG) begin
        boot_config_word_r <= wb_dat_i[CSP_CFG_W-1:0];
      end
      if (wb_adr_i == CSP_OFS_SECURE_CFG) begin
        secure_config_word_r <= wb_dat_i[CSP_CFG_W-1:0];
      end
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    case (wb_adr_i)
      CSP_OFS_BOOT_CFG: begin
        rd_data[CSP_CFG_W-1:0] = boot_config_word_r;
      end
      CSP_OFS_SECURE_CFG: begin
        rd_data[CSP_CFG_W-1:0] = secure_config_word_r;
      end
      CSP_OFS_BOOT_END: begin
        rd_data[CSP_FA_W-1:0] = boot_end_r;
      end
      CSP_OFS_SECURE_END: begin
        rd_data[CSP_FA_W-1:0] = sec_end_r;
      end
      CSP_OFS_RAM_LIMIT: begin
        rd_data[15:0] = bram_size_r;
        rd_data[31:16] = sram_size_r;
      end
      CSP_OFS_STATUS: begin
        rd_data[CSP_ST_BOOT_ON] = boot_on_r;
        rd_data[CSP_ST_SEC_ON] = sec_on_r;
        rd_data[CSP_ST_BOOT_HI] = boot_on_r && !boot_segment_size_code[2];
        rd_data[CSP_ST_SEC_HI] = sec_on_r && !secure_segment_size_code[2];
        rd_data[CSP_ST_BRAM_ON] = bram_on_r;
        rd_data[CSP_ST_SRAM_ON] = sram_on_r;
        rd_data[CSP_ST_SMALL] = small_r;
      end
      CSP_OFS_DENY_CNT: begin
        rd_data[CSP_CNT_W-1:0] = deny_cnt_r;
      end
      default: begin
        rd_data = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // segment decode

  always_ff @(posedge clk) begin
    if (rst) begin
      small_r <= 1'b0;
    end else begin
      small_r <= small_variant;
    end
  end

  always_comb begin
    case (boot_segment_size_code[1:0])
      CSP_SZ_SMALL: begin
        boot_end_nxt = CSP_END_1K;
      end
      CSP_SZ_MID: begin
        boot_end_nxt = CSP_END_4K;
      end
      CSP_SZ_LARGE: begin
        boot_end_nxt = CSP_END_8K;
      end
      default: begin
        boot_end_nxt = CSP_FLASH_BASE;
      end
    endcase
  end

  always_comb begin
    case (secure_segment_size_code[1:0])
      CSP_SZ_SMALL: begin
        sec_end_nxt = CSP_END_4K;
      end
      CSP_SZ_MID: begin
        sec_end_nxt = CSP_END_8K;
      end
      CSP_SZ_LARGE: begin
        sec_end_nxt = CSP_END_16K;
      end
      default: begin
        sec_end_nxt = CSP_FLASH_BASE;
      end
    endcase
  end

  always_comb begin
    case (boot_ram_size_code)
      CSP_RAM_S: begin
        bram_size_nxt = CSP_BRAM_S;
      end
      CSP_RAM_M: begin
        bram_size_nxt = CSP_BRAM_M;
      end
      CSP_RAM_L: begin
        bram_size_nxt = CSP_BRAM_L;
      end
      default: begin
        bram_size_nxt = 16'h0000;
      end
    endcase
  end

  always_comb begin
    case (secure_ram_size_code)
      CSP_RAM_S: begin
        sram_total = CSP_SRAM_S;
      end
      CSP_RAM_M: begin
        sram_total = CSP_SRAM_M;
      end
      CSP_RAM_L: begin
        sram_total = CSP_SRAM_L;
      end
      default: begin
        sram_total = 16'h0000;
      end
    endcase
  end

  // boot flash window
  always_ff @(posedge clk) begin
    if (rst) begin
      boot_on_r <= 1'b0;
      boot_end_r <= CSP_FLASH_BASE;
    end else begin
      boot_on_r <= (boot_segment_size_code[1:0] != CSP_SZ_NONE);
      boot_end_r <= boot_end_nxt;
    end
  end

  // secure flash window starts one word past the boot end, or at the base with none; a boot
  // segment reaching the secure end leaves nothing to protect
  always_ff @(posedge clk) begin
    if (rst) begin
      sec_on_r <= 1'b0;
      sec_lo_r <= CSP_FLASH_BASE;
      sec_end_r <= CSP_FLASH_BASE;
    end else begin
      sec_on_r <= (secure_segment_size_code[1:0] != CSP_SZ_NONE) &&
        !small_variant &&
        !(boot_segment_size_code[1:0] != CSP_SZ_NONE &&
          boot_end_nxt >= sec_end_nxt);
      sec_lo_r <= (boot_segment_size_code[1:0] != CSP_SZ_NONE) ?
        boot_end_nxt + CSP_ADDR_STEP : CSP_FLASH_BASE;
      sec_end_r <= small_variant ? CSP_FLASH_BASE : sec_end_nxt;
    end
  end

  // ram windows: boot ram from the base up, secure ram right after it
  always_ff @(posedge clk) begin
    if (rst) begin
      bram_on_r <= 1'b0;
      bram_size_r <= 16'h0000;
      sram_on_r <= 1'b0;
      sram_size_r <= 16'h0000;
    end else begin
      bram_on_r <= (bram_size_nxt != 16'h0000);
      bram_size_r <= bram_size_nxt;
      sram_on_r <= (sram_total > bram_size_nxt) && !small_variant;
      sram_size_r <= (sram_total > bram_size_nxt && !small_variant) ?
        sram_total - bram_size_nxt : 16'h0000;
    end
  end

  assign bram_hi = CSP_RAM_BASE + bram_size_r - 16'h0001;
  assign sram_lo = CSP_RAM_BASE + bram_size_r;
  assign sram_hi = CSP_RAM_BASE + bram_size_r + sram_size_r - 16'h0001;

  ////////////////////////////////////////////////////////////////////
  // write gating

  csp_range_chk #(
    .W(CSP_FA_W)
  ) u_boot_flash (
    .addr(flash_wr_addr),
    .lo(CSP_FLASH_BASE),
    .hi(boot_end_r),
    .valid(boot_on_r),
    .hit(hit_boot_f)
  );

  csp_range_chk #(
    .W(CSP_FA_W)
  ) u_sec_flash (
    .addr(flash_wr_addr),
    .lo(sec_lo_r),
    .hi(sec_end_r),
    .valid(sec_on_r),
    .hit(hit_sec_f)
  );

  csp_range_chk #(
    .W(CSP_RA_W)
  ) u_boot_ram (
    .addr(ram_wr_addr),
    .lo(CSP_RAM_BASE),
    .hi(bram_hi),
    .valid(bram_on_r),
    .hit(hit_boot_r)
  );

  csp_range_chk #(
    .W(CSP_RA_W)
  ) u_sec_ram (
    .addr(ram_wr_addr),
    .lo(sram_lo),
    .hi(sram_hi),
    .valid(sram_on_r),
    .hit(hit_sec_r)
  );

  logic flash_block;
  logic ram_block;

  // write-protect bit 0 means protected
  assign flash_block = (hit_boot_f && !boot_write_protect) ||
    (hit_sec_f && !secure_write_protect);
  assign ram_block = (hit_boot_r && !boot_write_protect) ||
    (hit_sec_r && !secure_write_protect);

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_wr_go <= 1'b0;
      flash_wr_deny <= 1'b0;
    end else begin
      flash_wr_go <= flash_wr_req && !flash_block;
      flash_wr_deny <= flash_wr_req && flash_block;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ram_wr_go <= 1'b0;
      ram_wr_deny <= 1'b0;
    end else begin
      ram_wr_go <= ram_wr_req && !ram_block;
      ram_wr_deny <= ram_wr_req && ram_block;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // denied write counter; saturates, a write clears it, and denials in
  // the clearing cycle still count so none are lost

  always_comb begin
    deny_cnt_nxt = deny_cnt_r;
    if (wb_wr_lane0 && wb_adr_i == CSP_OFS_DENY_CNT) begin
      deny_cnt_nxt = 16'h0000;
    end
    if (deny_cnt_nxt < 16'hfffe) begin
      deny_cnt_nxt = deny_cnt_nxt +
        {15'h0000, flash_wr_req && flash_block} +
        {15'h0000, ram_wr_req && ram_block};
    end else if (deny_cnt_nxt == 16'hfffe &&
                 ((flash_wr_req && flash_block) ||
                  (ram_wr_req && ram_block))) begin
      deny_cnt_nxt = 16'hffff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      deny_cnt_r <= 16'h0000;
    end else begin
      deny_cnt_r <= deny_cnt_nxt;
    end
  end

endmodule

// *** tb/csp_top_asserts.sv ***
// port-level assertions for the code segment protection block.
// assumes the testbench is the only bus master and write requester.
`timescale 1ns/1ps
module csp_top_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic small_variant,
  input wire logic flash_wr_req,
  input wire logic [csp_pkg::CSP_FA_W-1:0] flash_wr_addr,
  input wire logic flash_wr_go,
  input wire logic flash_wr_deny,
  input wire logic ram_wr_req,
  input wire logic [csp_pkg::CSP_RA_W-1:0] ram_wr_addr,
  input wire logic ram_wr_go,
  input wire logic ram_wr_deny
);
  import csp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_flash_answer: assert property (
    flash_wr_req |=> flash_wr_go ^ flash_wr_deny)
    else $error("flash request without exactly one answer");
  a_flash_quiet: assert property (
    !flash_wr_req |=> !flash_wr_go && !flash_wr_deny)
    else $error("flash answer without request");
  a_ram_answer: assert property (
    ram_wr_req |=> ram_wr_go ^ ram_wr_deny)
    else $error("ram request without exactly one answer");
  a_ram_quiet: assert property (
    !ram_wr_req |=> !ram_wr_go && !ram_wr_deny)
    else $error("ram answer without request");
  // no segment reaches past the largest secure end
  a_flash_high_free: assert property (
    flash_wr_req && flash_wr_addr > CSP_END_16K |=> flash_wr_go)
    else $error("flash write above all segments blocked");
  a_ram_outside_free: assert property (
    ram_wr_req && (ram_wr_addr < CSP_RAM_BASE || ram_wr_addr >= 16'h1800)
    |=> ram_wr_go)
    else $error("ram write outside protected area blocked");
  a_small_no_secure: assert property (
    small_variant && flash_wr_req && flash_wr_addr > CSP_END_8K
    |=> flash_wr_go)
    else $error("small variant blocked a secure write");
  a_unmapped_zero: assert property (
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h1c
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  c_flash_deny: cover property (flash_wr_deny);
  c_ram_deny: cover property (ram_wr_deny);
  c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule
bind csp_top csp_top_asserts csp_top_asserts_inst (.clk(clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .small_variant(small_variant), .flash_wr_req(flash_wr_req),
  .flash_wr_addr(flash_wr_addr), .flash_wr_go(flash_wr_go),
  .flash_wr_deny(flash_wr_deny), .ram_wr_req(ram_wr_req),
  .ram_wr_addr(ram_wr_addr), .ram_wr_go(ram_wr_go),
  .ram_wr_deny(ram_wr_deny));

// *** tb/csp_top_tb.sv ***
// self-checking bench for the code segment protection block.
// drives wishbone and both write request ports directly.
`timescale 1ns/1ps
module csp_top_tb;
  import csp_pkg::*;
  logic clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, small_variant = 0, flash_wr_req = 0, ram_wr_req = 0;
  logic [23:0] flash_wr_addr = 24'h0, e;
  logic [15:0] ram_wr_addr = 16'h0, tot, net;
  logic flash_wr_go, flash_wr_deny, ram_wr_go, ram_wr_deny;
  int failures = 0, cmp_count = 0, dn = 0;
  always #2 clk = ~clk;
  csp_top csp_top_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .small_variant(small_variant),
    .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr),
    .flash_wr_go(flash_wr_go), .flash_wr_deny(flash_wr_deny),
    .ram_wr_req(ram_wr_req), .ram_wr_addr(ram_wr_addr),
    .ram_wr_go(ram_wr_go), .ram_wr_deny(ram_wr_deny));
  //////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] id, logic [31:0] x,
    logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      $display("ERROR %s %h exp %h got %h", nm, id, x, g);
      failures++;
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("ERROR ack wait exp 1 got 0");
      results();
    end
    // idle cycle plus time for the decode stage to settle
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    wb(1, a, d, 4'hf);
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] x);
    wb(0, a, 32'h0, 4'hf);
    chk("reg", a, x, q);
  endtask
  // one request, answer checked one cycle after it is taken
  task automatic wp(bit ram, logic [23:0] a, bit dny);
    if (ram) begin
      ram_wr_req <= 1'b1;
      ram_wr_addr <= a[15:0];
    end else begin
      flash_wr_req <= 1'b1;
      flash_wr_addr <= a;
    end
    @(posedge clk);
    ram_wr_req <= 1'b0;
    flash_wr_req <= 1'b0;
    @(posedge clk);
    if (ram) chk("ram", a, {30'h0, !dny, dny}, {ram_wr_go, ram_wr_deny});
    else chk("flash", a, {30'h0, !dny, dny}, {flash_wr_go, flash_wr_deny});
    if (dny) dn++;
  endtask
  function automatic logic [23:0] bend(logic [1:0] c);
    case (c)
      2'h2: return CSP_END_1K;
      2'h1: return CSP_END_4K;
      2'h0: return CSP_END_8K;
      default: return 24'h0;
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(CSP_OFS_BOOT_CFG, 32'h3f);
    rc(CSP_OFS_SECURE_CFG, 32'h3f);
    rc(CSP_OFS_BOOT_END, 32'h0);
    rc(CSP_OFS_SECURE_END, 32'h0);
    rc(CSP_OFS_RAM_LIMIT, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(CSP_OFS_BOOT_CFG, {26'h0, 2'h3, c[2:0], 1'b0});
      e = bend(c[1:0]);
      rc(CSP_OFS_BOOT_END, {8'h0, e});
      // status: boot on when sized, and high security when the top code bit is also 0
      rc(CSP_OFS_STATUS,
        {29'h0, e != 0 && !c[2], 1'b0, e != 0});
      wp(0, 24'h0, e != 0);
      if (e != 0) wp(0, e, 1);
      wp(0, e + 24'h2, 0);
    end
    wr(CSP_OFS_BOOT_CFG, 32'h3d);
    wp(0, CSP_END_1K, 0);
    for (int c = 0; c < 4; c++) begin
      wr(CSP_OFS_BOOT_CFG, {26'h0, c[1:0], 4'he});
      tot = c == 2 ? 16'h80 : c == 1 ? 16'h100 : c == 0 ? 16'h400 : 16'h0;
      rc(CSP_OFS_RAM_LIMIT, {16'h0, tot});
      wp(1, 24'h7ff, 0);
      if (tot != 0) wp(1, {8'h0, 16'h800 + tot - 16'h1}, 1);
      wp(1, {8'h0, 16'h800 + tot}, 0);
    end
    for (int c = 0; c < 8; c++) begin
      wr(CSP_OFS_BOOT_CFG, 32'h2c);
      wr(CSP_OFS_SECURE_CFG, {26'h0, c[1:0], c[2:0], 1'b0});
      e = c[1:0] == 2 ? CSP_END_4K : c[1:0] == 1 ? CSP_END_8K :
        c[1:0] == 0 ? CSP_END_16K : 24'h0;
      tot = c[1:0] == 2 ? 16'h100 : c[1:0] == 1 ? 16'h800 :
        c[1:0] == 0 ? 16'h1000 : 16'h0;
      net = tot == 0 ? 16'h0 : tot - 16'h80;
      rc(CSP_OFS_SECURE_END, {8'h0, e});
      rc(CSP_OFS_RAM_LIMIT, {net, 16'h80});
      wp(0, CSP_END_1K, 1);
      wp(0, 24'h800, e != 0);
      if (e != 0) wp(0, e, 1);
      // with no secure segment, probe above the protected boot segment
      wp(0, e == 0 ? CSP_END_16K : e + 24'h2, 0);
      if (net != 0) wp(1, 24'h880, 1);
      // first byte past secure ram; past boot ram when none is defined
      wp(1, {8'h0, 16'h880 + net}, 0);
    end
    wr(CSP_OFS_SECURE_CFG, 32'h1);
    rc(CSP_OFS_STATUS, 32'h3b);
    wp(0, 24'h800, 0);
    wp(0, CSP_END_16K, 0);
    wp(1, 24'h880, 0);
    wp(0, CSP_END_1K, 1);
    wr(CSP_OFS_SECURE_CFG, 32'h0);
    small_variant <= 1'b1;
    repeat (3) @(posedge clk);
    rc(CSP_OFS_SECURE_END, 32'h0);
    rc(CSP_OFS_RAM_LIMIT, 32'h80);
    rc(CSP_OFS_STATUS, 32'h51);
    wp(0, 24'h800, 0);
    wp(0, 24'h4000, 0);
    wp(1, 24'h880, 0);
    small_variant <= 1'b0;
    wb(1, CSP_OFS_BOOT_CFG, 32'h3f, 4'he);
    rc(CSP_OFS_BOOT_CFG, 32'h2c);
    wr(8'h1c, 32'hffffffff);
    rc(8'h1c, 32'h0);
    rc(CSP_OFS_DENY_CNT, dn);
    wr(CSP_OFS_DENY_CNT, 32'h0);
    rc(CSP_OFS_DENY_CNT, 32'h0);
    results();
  end
endmodule
